/* design/ctbp_top.sv */
// Buffer-pair transmit control registers with outcome flags and interrupt
`timescale 1ns/1ps
`include "ctbp_defs.svh"

module ctbp_top
  import ctbp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`CTBP_ADDR_W-1:0] reg_addr,
  input wire logic [`CTBP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`CTBP_DATA_W-1:0] reg_rdata,
  input wire ctbp_engine_ev_s eng_ev,
  output ctbp_engine_cfg_s eng_cfg,
  output logic irq
);

  localparam int NB = `CTBP_NUM_BUFS;
  localparam int NP = `CTBP_NUM_PAIRS;

  // Next state of one buffer's control byte
  function automatic ctbp_buf_ctrl_s buf_next(
    input ctbp_buf_ctrl_s cur,
    input logic wr,
    input logic [7:0] wb,
    input logic done,
    input logic eng_abort,
    input logic lost,
    input logic err
  );
    ctbp_buf_ctrl_s n;
    logic sw_set;
    logic sw_abort;
    logic tx;
    n = cur;
    tx = cur.dir;
    sw_set = wr & wb[`CTBP_BIT_SEND_REQ] & ~cur.send_req;
    sw_abort = wr & ~wb[`CTBP_BIT_SEND_REQ] & cur.send_req & tx & ~done;
    if (wr) begin
      // Outcome flags are read-only; the written bits are ignored, but a new send request clears them
      n.dir = wb[`CTBP_BIT_DIR];
      n.send_req = wb[`CTBP_BIT_SEND_REQ];
      n.rtr_en = wb[`CTBP_BIT_RTR_EN];
      n.pri = wb[`CTBP_BIT_PRI_HI:`CTBP_BIT_PRI_LO];
    end
    if (sw_set) begin
      n.aborted = 1'b0;
      n.arb_lost = 1'b0;
      n.bus_err = 1'b0;
    end
    // A software write in the same cycle wins the request bit: a fresh queueing is not lost
    if (done && tx && !wr) begin
      n.send_req = 1'b0;
    end
    if (done && tx) begin
      n.aborted = 1'b0;
    end
    // Hardware sets come last so an event beats a same-cycle clear
    if ((eng_abort && tx && cur.send_req) || sw_abort) begin
      n.aborted = 1'b1;
    end
    if (eng_abort && tx && !wr) begin
      n.send_req = 1'b0;
    end
    if (lost && tx) begin
      n.arb_lost = 1'b1;
    end
    if (err && tx) begin
      n.bus_err = 1'b1;
    end
    return n;
  endfunction

  // Only control and status live here; message words are fetched by the engine from shared memory
  ctbp_buf_ctrl_s buf_q [NB];
  ctbp_buf_ctrl_s buf_d [NB];
  logic [`CTBP_DATA_W-1:0] irq_stat_q;
  logic [`CTBP_DATA_W-1:0] irq_stat_d;
  logic [`CTBP_DATA_W-1:0] irq_en_q;
  logic [`CTBP_DATA_W-1:0] rdata_q;
  logic [`CTBP_DATA_W-1:0] rdata_d;
  logic irq_q;
  logic [NP-1:0] ctrl_wr;
  logic [`CTBP_DATA_W-1:0] ctrl_word [NP];
  logic [NB-1:0] done_set;
  logic [NB-1:0] abort_set;
  logic [`CTBP_DATA_W-1:0] irq_clr;
  logic [`CTBP_DATA_W-1:0] irq_set;
  logic wr_en;
  logic wr_clr;

  assign wr_en = reg_wr & (reg_addr == `CTBP_OFF_IRQ_EN);
  assign wr_clr = reg_wr & (reg_addr == `CTBP_OFF_IRQ_CLR);
  assign irq_clr = wr_clr ? reg_wdata : `CTBP_DATA_W'(0);

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pair
      assign ctrl_wr[gp] = reg_wr & (reg_addr == (`CTBP_OFF_CTRL0 + 4'(gp)));
      // Even buffer in the low byte, odd buffer in the high byte
      assign ctrl_word[gp] = {buf_q[2*gp+1], buf_q[2*gp]};
    end
  endgenerate

  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_buf
      // Same byte layout for both halves of a control word
      assign buf_d[gb] = buf_next(buf_q[gb], ctrl_wr[gb/2], reg_wdata[8*(gb%2) +: 8],
                                  eng_ev.done[gb], eng_ev.aborted[gb],
                                  eng_ev.arb_lost[gb], eng_ev.bus_err[gb]);
      assign done_set[gb] = eng_ev.done[gb] & buf_q[gb].dir;
      assign abort_set[gb] = ~buf_q[gb].aborted & buf_d[gb].aborted;
      assign eng_cfg.send_req[gb] = buf_q[gb].send_req;
      assign eng_cfg.dir[gb] = buf_q[gb].dir;
      assign eng_cfg.rtr_en[gb] = buf_q[gb].rtr_en;
      assign eng_cfg.pri[2*gb +: 2] = buf_q[gb].pri;

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          buf_q[gb] <= ctbp_buf_ctrl_s'(8'h00);
        end else begin
          buf_q[gb] <= buf_d[gb];
        end
      end
    end
  endgenerate

  // Sticky status: a new event in the clearing cycle survives the clear
  assign irq_set = {abort_set, done_set};
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  // Read selection; unmapped offsets and the write-only clear read as zero
  assign rdata_d = !reg_rd ? `CTBP_RDATA_RST :
                   (reg_addr == `CTBP_OFF_CTRL0) ? ctrl_word[0] :
                   (reg_addr == `CTBP_OFF_CTRL1) ? ctrl_word[1] :
                   (reg_addr == `CTBP_OFF_CTRL2) ? ctrl_word[2] :
                   (reg_addr == `CTBP_OFF_CTRL3) ? ctrl_word[3] :
                   (reg_addr == `CTBP_OFF_IRQ_STAT) ? irq_stat_q :
                   (reg_addr == `CTBP_OFF_IRQ_EN) ? irq_en_q :
                   `CTBP_RDATA_RST;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= `CTBP_IRQ_STAT_RST;
      irq_en_q <= `CTBP_IRQ_EN_RST;
      rdata_q <= `CTBP_RDATA_RST;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_en) begin
        irq_en_q <= reg_wdata;
      end
      rdata_q <= rdata_d;
      // Registered to keep the output glitch-free; built from the next status so it rises with the status bit
      irq_q <= |(irq_stat_d & irq_en_q);
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;

endmodule // ctbp_top

/* design/ctbp_defs.svh */
// Offsets, field positions, reset values and widths of the buffer-pair transmit control block
`ifndef CTBP_DEFS_SVH
`define CTBP_DEFS_SVH

`define CTBP_ADDR_W 4
`define CTBP_DATA_W 16
`define CTBP_NUM_PAIRS 4
`define CTBP_NUM_BUFS 8

// Register offsets (word index on the plain register port)
`define CTBP_OFF_CTRL0 4'h0
`define CTBP_OFF_CTRL1 4'h1
`define CTBP_OFF_CTRL2 4'h2
`define CTBP_OFF_CTRL3 4'h3
`define CTBP_OFF_IRQ_STAT 4'h4
`define CTBP_OFF_IRQ_EN 4'h5
`define CTBP_OFF_IRQ_CLR 4'h6

// Field positions inside one buffer byte; the high byte repeats them
`define CTBP_BIT_DIR 7
`define CTBP_BIT_ABORTED 6
`define CTBP_BIT_ARB_LOST 5
`define CTBP_BIT_BUS_ERR 4
`define CTBP_BIT_SEND_REQ 3
`define CTBP_BIT_RTR_EN 2
`define CTBP_BIT_PRI_HI 1
`define CTBP_BIT_PRI_LO 0

// Interrupt status layout: done bits low byte, aborted bits high byte
`define CTBP_IRQ_DONE_LSB 0
`define CTBP_IRQ_ABORT_LSB 8

// Reset values
`define CTBP_CTRL_RST 16'h0000
`define CTBP_IRQ_STAT_RST 16'h0000
`define CTBP_IRQ_EN_RST 16'h0000
`define CTBP_RDATA_RST 16'h0000

`endif

/* design/ctbp_pkg.sv */
// Types shared by the buffer-pair transmit control block
package ctbp_pkg;

  // One buffer's control byte, in register bit order 7..0
  typedef struct packed {
    logic dir;
    logic aborted;
    logic arb_lost;
    logic bus_err;
    logic send_req;
    logic rtr_en;
    logic [1:0] pri;
  } ctbp_buf_ctrl_s;

  // Outcome pulses from the protocol engine, one bit per buffer
  typedef struct packed {
    logic [7:0] done;
    logic [7:0] aborted;
    logic [7:0] arb_lost;
    logic [7:0] bus_err;
  } ctbp_engine_ev_s;

  // Settings handed to the protocol engine, one entry per buffer
  typedef struct packed {
    logic [7:0] send_req;
    logic [7:0] dir;
    logic [7:0] rtr_en;
    logic [15:0] pri;
  } ctbp_engine_cfg_s;

endpackage

/* tb/ctbp_engine_model.sv */
// Behavioural protocol engine that reports send outcomes per buffer
`timescale 1ns/1ps
module ctbp_engine_model
  import ctbp_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [2:0] idx,
  input wire ctbp_engine_cfg_s eng_cfg,
  output ctbp_engine_ev_s eng_ev = '0
);
  // Only queued buffers get an outcome, as a real engine never reports an idle one
  always @(posedge clk) begin
    eng_ev <= '0;
    if (go && eng_cfg.send_req[idx]) begin
      case (kind)
        2'h0: eng_ev.done[idx] <= 1'h1;
        2'h1: eng_ev.aborted[idx] <= 1'h1;
        2'h2: eng_ev.arb_lost[idx] <= 1'h1;
        default: eng_ev.bus_err[idx] <= 1'h1;
      endcase
    end
  end
endmodule // ctbp_engine_model

/* tb/ctbp_top_properties.sv */
// Port-level assertions for the buffer-pair transmit control block
`timescale 1ns/1ps
`include "ctbp_defs.svh"
module ctbp_chk
  import ctbp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`CTBP_ADDR_W-1:0] reg_addr,
  input wire logic [`CTBP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`CTBP_DATA_W-1:0] reg_rdata,
  input wire ctbp_engine_ev_s eng_ev,
  input wire ctbp_engine_cfg_s eng_cfg,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  byte_pairing_a: assert property (reg_wr && reg_addr == 4'h0 |=>
    eng_cfg.send_req[1:0] == {$past(reg_wdata[11]), $past(reg_wdata[3])}) else $error("pair write");
  done_clears_req_a: assert property (eng_ev.done[0] && eng_cfg.dir[0] && !reg_wr |=>
    !eng_cfg.send_req[0]) else $error("done kept request");
  engine_abort_a: assert property (eng_ev.aborted[1] && eng_cfg.dir[1] && eng_cfg.send_req[1] && !reg_wr |=>
    !eng_cfg.send_req[1]) else $error("abort kept request");
  arb_keeps_req_a: assert property (eng_ev.arb_lost[0] && eng_cfg.send_req[0] && !reg_wr
    && !eng_ev.done[0] && !eng_ev.aborted[0] |=> eng_cfg.send_req[0]) else $error("arb lost request");
  err_keeps_req_a: assert property (eng_ev.bus_err[1] && eng_cfg.send_req[1] && !reg_wr
    && !eng_ev.done[1] && !eng_ev.aborted[1] |=> eng_cfg.send_req[1]) else $error("error lost request");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == '0) else $error("unmapped");
  cfg_holds_a: assert property (!reg_wr && eng_ev == '0 |=> $stable(eng_cfg)) else $error("cfg moved");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0) else $error("rdata not idle");
  irq_masked_a: assert property (reg_wr && reg_addr == 4'h5 && reg_wdata == '0 ##1
    !(reg_wr && reg_addr == 4'h5) |=> !irq) else $error("irq while masked");
endmodule // ctbp_chk
bind ctbp_top ctbp_chk ctbp_chk_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .eng_ev, .eng_cfg, .irq);

/* tb/tb_top.sv */
// Self-checking bench for the buffer-pair transmit control block
`timescale 1ns/1ps
module tb_top import ctbp_pkg::*;;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, go = 0, irq;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic [1:0] kind = 2'h0;
  logic [2:0] idx = 3'h0;
  ctbp_engine_ev_s eng_ev;
  ctbp_engine_cfg_s eng_cfg;
  int n_fail = 0, samples_checked = 0;
  ctbp_top ctbp_top_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .eng_ev, .eng_cfg, .irq);
  ctbp_engine_model ctbp_engine_model_i (.clk, .go, .kind, .idx, .eng_cfg, .eng_ev);
  initial forever #25 clk = ~clk;
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 cmp("rdata", e, reg_rdata);
  endtask
  // Kind 0 done, 1 abort, 2 arbitration lost, 3 bus error; waits until irq has settled
  task automatic ev(logic [1:0] k, logic [2:0] b);
    @(posedge clk);
    go <= 1;
    kind <= k;
    idx <= b;
    @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
    $display("test reset done");
    wr(4'h5, 16'hFFFF);
    wr(4'h0, 16'h88F8);
    rd(4'h0, 16'h8888);
    ev(2'h2, 3'h0);
    ev(2'h3, 3'h1);
    rd(4'h0, 16'h98A8);
    wr(4'h0, 16'h8080);
    rd(4'h0, 16'hD0E0);
    rd(4'h4, 16'h0300);
    cmp("irq", 16'h0001, {15'h0, irq});
    $display("test flags done");
    wr(4'h0, 16'h8888);
    rd(4'h0, 16'h8888);
    wr(4'h6, 16'hFFFF);
    ev(2'h0, 3'h0);
    ev(2'h1, 3'h1);
    rd(4'h0, 16'hC080);
    rd(4'h4, 16'h0201);
    wr(4'h5, 16'h0000);
    rd(4'h5, 16'h0000);
    cmp("irq", 16'h0000, {15'h0, irq});
    $display("test outcomes done");
    wr(4'h1, 16'h0F87);
    rd(4'h1, 16'h0F87);
    cmp("cfg_req", 16'h0008, {8'h00, eng_cfg.send_req});
    cmp("cfg_dir", 16'h0007, {8'h00, eng_cfg.dir});
    cmp("cfg_rtr", 16'h000C, {8'h00, eng_cfg.rtr_en});
    cmp("cfg_pri", 16'h00F0, eng_cfg.pri);
    ev(2'h0, 3'h3);
    rd(4'h1, 16'h0F87);
    rd(4'h4, 16'h0201);
    $display("test receive buffer done");
    close_out;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    close_out;
  end
endmodule // tb_top
